// ===== rtl/mbi_pkg.sv
package mbi_pkg;

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
localparam logic [3:0] ADDR_BUS_CTRL = 4'h0;
localparam logic [3:0] ADDR_CACHE_CFG = 4'h1;
localparam logic [3:0] ADDR_PORT_SIZE = 4'h2;
localparam logic [3:0] ADDR_STATUS = 4'h3;
localparam logic [3:0] ADDR_STORE_ADDR = 4'h4;
localparam logic [3:0] ADDR_STORE_DATA = 4'h5;
localparam logic [3:0] ADDR_READ_REQ = 4'h6;
localparam logic [3:0] ADDR_READ_DATA = 4'h7;

// bus control fields
localparam int BC_EXT_HOLD = 0;
localparam int BC_TURN_LO = 1;
localparam int BC_RD_STROBE = 3;
localparam int BC_WR_STROBE = 4;
localparam int BC_BURST = 5;
localparam logic [31:0] BUS_CTRL_RESET = 32'h0000_0018;
localparam logic [31:0] CACHE_CFG_RESET = 32'h0000_0000;
localparam logic [31:0] PORT_SIZE_RESET = 32'h0000_0000;

// port size codes, two bits per sub-region
localparam logic [1:0] PS_32 = 2'h0;
localparam logic [1:0] PS_8 = 2'h1;
localparam logic [1:0] PS_16 = 2'h2;

// read request kinds
localparam logic [1:0] RK_UNCACHED = 2'h0;
localparam logic [1:0] RK_DATA = 2'h1;
localparam logic [1:0] RK_INSTR = 2'h2;

// clocking: input clock runs at twice the processor rate
localparam int CLK_MHZ = 25;
localparam int CORE_DIV = 2;
localparam int WBUF_DEPTH = 4;
localparam int RBUF_DEPTH = 4;

typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
} mbi_store_type;

typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
    logic burst;
    logic [3:0] be_n;
} mbi_ctrl_type;

endpackage

// ===== rtl/mbi_unit.sv
`timescale 1ns/10ps
// Function
// [R01] address then data share one 32-pin multiplexed bus
// [R02] address latch strobe marks the address phase for external capture
// [R03] extended hold keeps address half a clock after strobe falls
// [R04] four-deep store fifo retired as bus writes at memory pace
// [R05] stores to narrow ports split into several narrow bus writes
// [R06] single-word reads finish with request/acknowledge handshake
// [R07] quad reads use handshake or burst, one word per clock; each burst word here takes four input clocks
// [R08] read words collect in four-entry fifo before cache refill
// [R09] narrow reads are assembled into full words, fetches alike
// [R10] port size control gives each sub-region 8, 16 or 32 bits
// [R11] arbiter grants bus to external master, who drives only granted
// [R12] every store passes through write buffer, write-through
// [R13] double-rate input clock; core timing derived from it
// [R14] instruction misses always refill with four-word reads
// [R15] cache config selects data block size and refill length
// [R16] bus control register steers interface signal behaviour
// [R17] data refill one or four words; uncached reads single word
// [R18] turnaround gap lengthened when bus direction changes
// [R19] strobes selectable for reads, writes or both
// [R20] new store stalls while all four entries are full; here it is refused and flagged instead
// [R21] narrow pieces go in ascending order, only their byte lanes
module mbi_unit #(
    parameter int TURN_MAX = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [31:0] ad_out,
    output logic ad_oe,
    input wire logic [31:0] ad_in,
    output logic ale,
    output logic rd_n,
    output logic wr_n,
    output logic burst_n,
    output logic [3:0] be_n,
    input wire logic ack_n,
    input wire logic br_n,
    output logic bgnt_n,
    output logic sys_clk
);

initial begin
    if (TURN_MAX < 1 || TURN_MAX > 3) begin
        $error("TURN_MAX out of range");
    end
end

// ----------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------
logic [2:0] ack_sync_q;
logic [2:0] br_sync_q;
logic ack_q;
logic br_q;

always_ff @(posedge clk) begin
    if (rst) begin
        ack_sync_q <= 3'h7;
        br_sync_q <= 3'h7;
        ack_q <= 1'b0;
        br_q <= 1'b0;
    end else begin
        ack_sync_q <= {ack_sync_q[1:0], ack_n};
        br_sync_q <= {br_sync_q[1:0], br_n};
        if (ack_sync_q[1] == ack_sync_q[2]) begin
            ack_q <= ~ack_sync_q[2];
        end
        if (br_sync_q[1] == br_sync_q[2]) begin
            br_q <= ~br_sync_q[2];
        end
    end
end

// ----------------------------------------------------------------
// processor phase from double-rate clock
// ----------------------------------------------------------------
logic phase_q;

always_ff @(posedge clk) begin
    if (rst) begin
        phase_q <= 1'b0;
        sys_clk <= 1'b0;
    end else begin
        phase_q <= ~phase_q; // R13
        sys_clk <= ~phase_q; // R13
    end
end

// ----------------------------------------------------------------
// control registers
// ----------------------------------------------------------------
logic [31:0] bus_ctrl_q;
logic [31:0] cache_cfg_q;
logic [31:0] port_size_q;
logic [31:0] st_addr_q;
logic [1:0] rd_kind_q;
logic [31:0] rd_addr_q;
logic rd_start_q;

always_ff @(posedge clk) begin
    if (rst) begin
        bus_ctrl_q <= mbi_pkg::BUS_CTRL_RESET;
        cache_cfg_q <= mbi_pkg::CACHE_CFG_RESET;
        port_size_q <= mbi_pkg::PORT_SIZE_RESET;
        st_addr_q <= 32'h0000_0000;
    end else if (reg_wr) begin
        case (reg_addr)
            mbi_pkg::ADDR_BUS_CTRL: bus_ctrl_q <= reg_wdata; // R16
            mbi_pkg::ADDR_CACHE_CFG: cache_cfg_q <= reg_wdata; // R15
            mbi_pkg::ADDR_PORT_SIZE: port_size_q <= reg_wdata; // R10
            mbi_pkg::ADDR_STORE_ADDR: st_addr_q <= reg_wdata;
            default: ;
        endcase
    end
end

// ----------------------------------------------------------------
// write buffer
// ----------------------------------------------------------------
mbi_pkg::mbi_store_type wb_mem [mbi_pkg::WBUF_DEPTH];
logic [2:0] wb_wp_q;
logic [2:0] wb_rp_q;
logic wb_full;
logic wb_empty;
logic wb_push;
logic wb_pop;
logic st_drop_q;

assign wb_full = (wb_wp_q[1:0] == wb_rp_q[1:0]) &&
    (wb_wp_q[2] != wb_rp_q[2]);
assign wb_empty = (wb_wp_q == wb_rp_q);
assign wb_push = reg_wr && reg_addr == mbi_pkg::ADDR_STORE_DATA && !wb_full;

always_ff @(posedge clk) begin
    if (rst) begin
        wb_wp_q <= 3'h0;
        st_drop_q <= 1'b0;
    end else begin
        if (wb_push) begin
            wb_mem[wb_wp_q[1:0]] <= '{addr: st_addr_q, data: reg_wdata}; // R12
            wb_wp_q <= wb_wp_q + 3'h1; // R04
        end
        // store while full is refused and flagged
        if (reg_wr && reg_addr == mbi_pkg::ADDR_STORE_DATA && wb_full) begin
            st_drop_q <= 1'b1; // R20
        end else if (reg_rd && reg_addr == mbi_pkg::ADDR_STATUS) begin
            st_drop_q <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// bus sequencer
// ----------------------------------------------------------------
typedef enum {
    S_IDLE, S_TURN, S_ADDR, S_HOLD, S_DATA, S_NEXT, S_GRANT
} mbi_state_type;

mbi_state_type state_q;
logic [31:0] cur_addr_q;
logic [31:0] cur_data_q;
logic is_write_q;
logic last_write_q;
logic [1:0] words_q;
logic [1:0] piece_q;
logic [1:0] turn_q;
logic [1:0] psize;
logic [1:0] pieces;
logic [31:0] asm_q;
logic [31:0] rb_mem [mbi_pkg::RBUF_DEPTH];
logic [2:0] rb_wp_q;
logic [2:0] rb_rp_q;
logic [1:0] word_idx_q;
logic rd_busy_q;
logic quad;
logic rd_req;

assign rd_req = reg_wr && reg_addr == mbi_pkg::ADDR_READ_REQ;
assign psize = port_size_q[{cur_addr_q[31:28], 1'b0} +: 2]; // R10
assign pieces = (psize == mbi_pkg::PS_8) ? 2'h3 :
    (psize == mbi_pkg::PS_16) ? 2'h1 : 2'h0; // R05
assign quad = (rd_kind_q == mbi_pkg::RK_INSTR) ||
    (rd_kind_q == mbi_pkg::RK_DATA && cache_cfg_q[0]); // R14 R15 R17
assign wb_pop = state_q == S_NEXT && is_write_q && piece_q == pieces;

// synchronised ack lags; one ack must never finish two pieces
logic ack_used_q;

always_ff @(posedge clk) begin
    if (rst) begin
        ack_used_q <= 1'b0;
    end else if (state_q == S_DATA && ack_q && !ack_used_q) begin
        ack_used_q <= 1'b1; // R06
    end else if (!ack_q) begin
        ack_used_q <= 1'b0;
    end
end

always_ff @(posedge clk) begin
    if (rst) begin
        rd_kind_q <= mbi_pkg::RK_UNCACHED;
        rd_addr_q <= 32'h0000_0000;
        rd_start_q <= 1'b0;
    end else begin
        if (rd_req && !rd_start_q && !rd_busy_q) begin
            rd_kind_q <= reg_wdata[1:0];
            rd_addr_q <= {st_addr_q[31:4],
                (reg_wdata[1:0] == mbi_pkg::RK_UNCACHED) ?
                st_addr_q[3:0] : 4'h0};
            rd_start_q <= 1'b1;
        end else if (state_q == S_IDLE && rd_start_q && wb_empty &&
            !br_q) begin
            rd_start_q <= 1'b0;
        end
    end
end

always_ff @(posedge clk) begin
    if (rst) begin
        state_q <= S_IDLE;
        cur_addr_q <= 32'h0000_0000;
        cur_data_q <= 32'h0000_0000;
        is_write_q <= 1'b0;
        last_write_q <= 1'b0;
        words_q <= 2'h0;
        piece_q <= 2'h0;
        turn_q <= 2'h0;
        asm_q <= 32'h0000_0000;
        wb_rp_q <= 3'h0;
        rb_wp_q <= 3'h0;
        word_idx_q <= 2'h0;
        rd_busy_q <= 1'b0;
    end else begin
        case (state_q)
            S_IDLE: begin
                if (br_q) begin
                    state_q <= S_GRANT; // R11
                end else if (!wb_empty || (rd_start_q && wb_empty)) begin
                    // stores drain before reads so memory stays coherent
                    is_write_q <= !wb_empty;
                    cur_addr_q <= wb_empty ? rd_addr_q :
                        wb_mem[wb_rp_q[1:0]].addr;
                    cur_data_q <= wb_mem[wb_rp_q[1:0]].data;
                    words_q <= (wb_empty && quad) ? 2'h3 : 2'h0;
                    rd_busy_q <= wb_empty;
                    piece_q <= 2'h0;
                    turn_q <= bus_ctrl_q[mbi_pkg::BC_TURN_LO +: 2];
                    if (last_write_q != !wb_empty &&
                        bus_ctrl_q[mbi_pkg::BC_TURN_LO +: 2] != 2'h0) begin
                        state_q <= S_TURN; // R18
                    end else begin
                        state_q <= S_ADDR;
                    end
                end
            end
            S_TURN: begin
                turn_q <= turn_q - 2'h1;
                if (turn_q == 2'h1) begin
                    state_q <= S_ADDR; // R18
                end
            end
            S_ADDR: begin
                state_q <= bus_ctrl_q[mbi_pkg::BC_EXT_HOLD] ? S_HOLD : S_DATA; // R03
            end
            S_HOLD: state_q <= S_DATA; // R03
            S_DATA: begin
                if ((ack_q && !ack_used_q) ||
                    (!is_write_q && bus_ctrl_q[mbi_pkg::BC_BURST] &&
                    words_q != 2'h0 && phase_q)) begin
                    if (!is_write_q) begin
                        // lanes assemble in ascending byte order
                        case (pieces)
                            2'h3: asm_q[{piece_q, 3'h0} +: 8] <=
                                ad_in[{piece_q, 3'h0} +: 8]; // R09
                            2'h1: asm_q[{piece_q[0], 4'h0} +: 16] <=
                                ad_in[{piece_q[0], 4'h0} +: 16]; // R09
                            default: asm_q <= ad_in; // R06
                        endcase
                    end
                    state_q <= S_NEXT;
                end
            end
            S_NEXT: begin
                last_write_q <= is_write_q;
                if (piece_q != pieces) begin
                    piece_q <= piece_q + 2'h1; // R21
                    cur_addr_q <= cur_addr_q + ((pieces == 2'h3) ? 32'h1 : 32'h2);
                    state_q <= S_ADDR;
                end else if (is_write_q) begin
                    wb_rp_q <= wb_rp_q + 3'h1; // R04
                    state_q <= S_IDLE;
                end else begin
                    rb_mem[rb_wp_q[1:0]] <= asm_q; // R08
                    rb_wp_q <= rb_wp_q + 3'h1; // R08
                    piece_q <= 2'h0;
                    if (words_q != 2'h0) begin
                        words_q <= words_q - 2'h1; // R07
                        cur_addr_q <= {cur_addr_q[31:2] + 30'h1, 2'h0};
                        state_q <= S_ADDR;
                    end else begin
                        rd_busy_q <= 1'b0;
                        state_q <= S_IDLE;
                    end
                end
            end
            S_GRANT: begin
                if (!br_q) begin
                    state_q <= S_IDLE; // R11
                end
            end
            default: state_q <= S_IDLE;
        endcase
    end
end

// read buffer drained by software, one word per read
always_ff @(posedge clk) begin
    if (rst) begin
        rb_rp_q <= 3'h0;
    end else if (reg_rd && reg_addr == mbi_pkg::ADDR_READ_DATA &&
        rb_rp_q != rb_wp_q && !rd_busy_q) begin
        rb_rp_q <= rb_rp_q + 3'h1; // R08
    end
end

// ----------------------------------------------------------------
// pins
// ----------------------------------------------------------------
always_ff @(posedge clk) begin
    if (rst) begin
        ad_out <= 32'h0000_0000;
        ad_oe <= 1'b0;
        ale <= 1'b0;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        burst_n <= 1'b1;
        be_n <= 4'hF;
        bgnt_n <= 1'b1;
    end else begin
        ale <= state_q == S_ADDR; // R02
        // address leads, data follows on the same pins
        if (state_q == S_DATA && is_write_q) begin
            ad_out <= cur_data_q; // R01 R05
        end else begin
            ad_out <= cur_addr_q; // R01 R03
        end
        ad_oe <= state_q == S_ADDR || state_q == S_HOLD ||
            (state_q == S_DATA && is_write_q); // R01
        rd_n <= !(state_q == S_DATA && !is_write_q &&
            bus_ctrl_q[mbi_pkg::BC_RD_STROBE]); // R19
        wr_n <= !(state_q == S_DATA && is_write_q &&
            bus_ctrl_q[mbi_pkg::BC_WR_STROBE]); // R19
        burst_n <= !(state_q != S_IDLE && !is_write_q && words_q != 2'h0 &&
            bus_ctrl_q[mbi_pkg::BC_BURST]); // R07
        case (pieces)
            2'h3: be_n <= ~(4'h1 << cur_addr_q[1:0]); // R21
            2'h1: be_n <= cur_addr_q[1] ? 4'h3 : 4'hC; // R21
            default: be_n <= 4'h0;
        endcase
        bgnt_n <= !(state_q == S_GRANT && br_q); // R11
    end
end

// ----------------------------------------------------------------
// register read port
// ----------------------------------------------------------------
always_ff @(posedge clk) begin
    if (rst) begin
        reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
        case (reg_addr)
            mbi_pkg::ADDR_BUS_CTRL: reg_rdata <= bus_ctrl_q;
            mbi_pkg::ADDR_CACHE_CFG: reg_rdata <= cache_cfg_q;
            mbi_pkg::ADDR_PORT_SIZE: reg_rdata <= port_size_q;
            mbi_pkg::ADDR_STATUS: reg_rdata <= {23'h0, st_drop_q, rd_busy_q,
                rb_wp_q - rb_rp_q, wb_full, wb_empty};
            mbi_pkg::ADDR_STORE_ADDR: reg_rdata <= st_addr_q;
            mbi_pkg::ADDR_READ_DATA: reg_rdata <= rb_mem[rb_rp_q[1:0]];
            default: reg_rdata <= 32'h0000_0000;
        endcase
    end else begin
        reg_rdata <= 32'h0000_0000;
    end
end

// ----------------------------------------------------------------
// checks
// ----------------------------------------------------------------
a_grant_only_req: assert property (@(posedge clk) disable iff (rst)
    !bgnt_n |-> $past(br_q)) else $error("grant without request"); // R11
a_full_no_push: assert property (@(posedge clk) disable iff (rst)
    wb_full |=> !(wb_wp_q == $past(wb_wp_q) + 3'h1 &&
    wb_rp_q == $past(wb_rp_q)))
    else $error("store pushed into full buffer"); // R20
a_strobe_dir: assert property (@(posedge clk) disable iff (rst)
    !(rd_n == 1'b0 && wr_n == 1'b0)) else $error("read and write together"); // R19
a_phase_toggle: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> sys_clk != $past(sys_clk))
    else $error("core phase stuck"); // R13
a_ale_drives_addr: assert property (@(posedge clk) disable iff (rst)
    ale |-> ad_oe && rd_n && wr_n) else $error("strobe without address"); // R02
a_ext_hold_addr: assert property (@(posedge clk) disable iff (rst)
    ale && bus_ctrl_q[mbi_pkg::BC_EXT_HOLD] |=>
    ad_oe && !ale && ad_out == $past(ad_out))
    else $error("address not held"); // R03

endmodule

// ===== tb/mbi_mem_model.sv
`timescale 1ns/10ps
module mbi_mem_model (
    input wire logic clk,
    input wire logic [31:0] ad_out,
    input wire logic ad_oe,
    output logic [31:0] ad_in,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [3:0] be_n,
    output logic ack_n,
    input wire logic [3:0] dly
);
    logic [31:0] mem [16];
    logic [31:0] cur_a;
    logic [3:0] cnt;
    logic [31:0] alog [$];
    logic [3:0] blog [$];

    // ----------------------------------------------------------------
    // word memory with slow acknowledge
    // ----------------------------------------------------------------
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = {4{i[7:0]}} ^ 32'h0F1E_2D3C;
        end
        ad_in = 32'h0;
        ack_n = 1'b1;
        cur_a = 32'h0;
        cnt = 4'h0;
    end

    always @(posedge clk) begin
        if (ale && ad_oe) begin
            cur_a <= ad_out;
        end
        if (!wr_n || !rd_n) begin
            cnt <= (cnt == 4'hF) ? cnt : cnt + 4'h1;
            if (cnt == dly) begin
                ack_n <= 1'b0;
            end
        end else begin
            cnt <= 4'h0;
            ack_n <= 1'b1;
        end
        if ((!wr_n || !rd_n) && cnt == 4'h0) begin
            alog.push_back(cur_a);
            blog.push_back(be_n);
        end
        if (!wr_n && cnt == 4'h0) begin
            for (int b = 0; b < 4; b++) begin
                if (!be_n[b]) begin
                    mem[cur_a[5:2]][8*b +: 8] <= ad_out[8*b +: 8];
                end
            end
        end
        // released lines toggle so stale data never looks valid
        ad_in <= (!rd_n && !ale) ? mem[cur_a[5:2]] : ~ad_in;
    end
endmodule

// ===== tb/muxed_bus_interface_unit_tb.sv
`timescale 1ns/10ps
module muxed_bus_interface_unit_tb;
    logic clk, rst, reg_wr, reg_rd, ad_oe, ale, rd_n, wr_n, burst_n;
    logic ack_n, br_n, bgnt_n, sys_clk;
    logic [3:0] reg_addr, be_n, dly;
    logic [31:0] reg_wdata, reg_rdata, ad_out, ad_in, d;
    int fail_count, total_checks;

    mbi_unit dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .ad_out, .ad_oe, .ad_in, .ale, .rd_n, .wr_n,
        .burst_n, .be_n, .ack_n, .br_n, .bgnt_n, .sys_clk);
    mbi_mem_model mem_i (.clk, .ad_out, .ad_oe, .ad_in, .ale, .rd_n,
        .wr_n, .be_n, .ack_n, .dly);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // waits for n strobes, then lets the ack synchroniser settle
    task automatic wait_bus(input int n);
        int i;
        i = 0;
        while ((mem_i.alog.size() < n || !(rd_n && wr_n)) && i < 3000) begin
            @(posedge clk);
            i++;
        end
        repeat (12) @(posedge clk);
        if (i >= 3000) begin
            check(32'h0, 32'h1);
        end
    endtask

    function automatic logic [31:0] pat(input int i);
        pat = {4{i[7:0]}} ^ 32'h0F1E_2D3C;
    endfunction

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rd(mbi_pkg::ADDR_BUS_CTRL, d);
        check(d, mbi_pkg::BUS_CTRL_RESET);
        rd(mbi_pkg::ADDR_CACHE_CFG, d);
        check(d, mbi_pkg::CACHE_CFG_RESET);
        wr(mbi_pkg::ADDR_PORT_SIZE, 32'h0000_0006);
        rd(mbi_pkg::ADDR_PORT_SIZE, d);
        check(d, 32'h0000_0006);
        wr(mbi_pkg::ADDR_PORT_SIZE, mbi_pkg::PORT_SIZE_RESET);
    endtask

    // slow memory, long hold and turnaround, four stores in a row
    task automatic t_stores;
        mem_i.alog.delete();
        dly <= 4'h6;
        wr(mbi_pkg::ADDR_BUS_CTRL, mbi_pkg::BUS_CTRL_RESET | 32'h7);
        for (int k = 0; k < 4; k++) begin
            wr(mbi_pkg::ADDR_STORE_ADDR, 32'h4 * k);
            wr(mbi_pkg::ADDR_STORE_DATA, 32'hCAFE_0000 + k);
        end
        wait_bus(4);
        for (int k = 0; k < 4; k++) begin
            check(mem_i.alog[k], 32'h4 * k);
            check(mem_i.mem[k], 32'hCAFE_0000 + k);
        end
        rd(mbi_pkg::ADDR_STATUS, d);
        check(d & 32'h1, 32'h1);
        wr(mbi_pkg::ADDR_BUS_CTRL, mbi_pkg::BUS_CTRL_RESET);
        dly <= 4'h1;
    endtask

    task automatic t_narrow(input logic [1:0] ps, input int n,
            input logic [31:0] v);
        int st;
        logic [3:0] e;
        st = 4 / n;
        mem_i.alog.delete();
        mem_i.blog.delete();
        wr(mbi_pkg::ADDR_PORT_SIZE, {30'h0, ps});
        wr(mbi_pkg::ADDR_STORE_ADDR, 32'h0000_0010);
        wr(mbi_pkg::ADDR_STORE_DATA, v);
        wait_bus(n);
        check(mem_i.alog.size(), n);
        for (int k = 0; k < n; k++) begin
            e = 4'hF ^ (4'((1 << st) - 1) << (k * st));
            check(mem_i.alog[k], 32'h10 + k * st);
            check({28'h0, mem_i.blog[k]}, {28'h0, e});
        end
        check(mem_i.mem[4], v);
        wr(mbi_pkg::ADDR_PORT_SIZE, 32'h0);
    endtask

    task automatic t_read(input logic [1:0] kind, input logic cfg,
            input logic [1:0] ps, input int n, input int w);
        mem_i.alog.delete();
        wr(mbi_pkg::ADDR_CACHE_CFG, {31'h0, cfg});
        wr(mbi_pkg::ADDR_PORT_SIZE, {30'h0, ps});
        wr(mbi_pkg::ADDR_STORE_ADDR, 32'h0000_0020);
        wr(mbi_pkg::ADDR_READ_REQ, {30'h0, kind});
        wait_bus(w * n);
        check(mem_i.alog.size(), w * n);
        check(mem_i.alog[w * n - 1], 32'h20 + 4 * w - 4 / n);
        for (int k = 0; k < w; k++) begin
            rd(mbi_pkg::ADDR_READ_DATA, d);
            check(d, pat(8 + k));
        end
        wr(mbi_pkg::ADDR_PORT_SIZE, 32'h0);
    endtask

    task automatic t_arb;
        int i;
        i = 0;
        br_n <= 1'b0;
        while (bgnt_n !== 1'b0 && i < 100) begin
            @(posedge clk);
            #1 i++;
        end
        check({31'h0, bgnt_n}, 32'h0);
        repeat (4) begin
            @(posedge clk);
            #1 check({31'h0, ad_oe}, 32'h0);
        end
        br_n <= 1'b1;
        i = 0;
        while (bgnt_n !== 1'b1 && i < 100) begin
            @(posedge clk);
            #1 i++;
        end
        check({31'h0, bgnt_n}, 32'h1);
    endtask

    task automatic t_clk;
        logic p;
        @(posedge clk);
        #1 p = sys_clk;
        repeat (8) begin
            @(posedge clk);
            #1 check({31'h0, sys_clk}, {31'h0, ~p});
            p = sys_clk;
        end
    endtask

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    task automatic print_verdict;
        $display("checks=%0d failures=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // generous: slowest scenario needs about 200 cycles
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        br_n = 1'b1;
        dly = 4'h1;
        fail_count = 0;
        total_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_stores();
        t_narrow(mbi_pkg::PS_8, 4, 32'h8765_4321);
        t_narrow(mbi_pkg::PS_16, 2, 32'h1357_9BDF);
        t_read(mbi_pkg::RK_UNCACHED, 1'b1, mbi_pkg::PS_32, 1, 1);
        t_read(mbi_pkg::RK_INSTR, 1'b0, mbi_pkg::PS_32, 1, 4);
        t_read(mbi_pkg::RK_DATA, 1'b0, mbi_pkg::PS_32, 1, 1);
        t_read(mbi_pkg::RK_DATA, 1'b1, mbi_pkg::PS_16, 2, 4);
        t_read(mbi_pkg::RK_INSTR, 1'b0, mbi_pkg::PS_8, 4, 4);
        t_arb();
        t_clk();
        print_verdict();
    end
endmodule
